//--- rtl/seq_pkg.sv
// constants, register map and state layout of the status event and error queue block
// assumes a 32-bit classic wishbone slave port and a single 200 MHz clock
package seq_pkg;

    // clock rate, kept for reference by timing users
    localparam int CLK_PERIOD_NS = 5;

    // error queue: 29 ordinary slots plus one for the overflow entry
    localparam int ERR_DEPTH = 30;
    localparam int ERR_CW = 5;
    localparam int ERR_W = 16;
    localparam logic [ERR_W-1:0] ERR_OVERFLOW_CODE = 16'hfea2; // -350, two's complement
    localparam logic [ERR_W-1:0] ERR_NONE_CODE = 16'h0000;

    // output queue of response bytes
    localparam int OUTQ_DEPTH = 16;
    localparam int OUTQ_CW = 5;
    localparam int OUTQ_W = 8;

    // wishbone data width and register byte offsets
    localparam int WB_DW = 32;
    localparam int WB_AW = 8;
    localparam logic [WB_AW-1:0] ADR_STATUS_BYTE = 8'h00;
    localparam logic [WB_AW-1:0] ADR_ACTIVITY_SUMMARY_BIT_STATUS = 8'h04;
    localparam logic [WB_AW-1:0] ADR_ACTIVITY_SUMMARY_BIT_MASK = 8'h08;
    localparam logic [WB_AW-1:0] ADR_TRIG_QUERY = 8'h0c;
    localparam logic [WB_AW-1:0] ADR_CAPT_QUERY = 8'h10;
    localparam logic [WB_AW-1:0] ADR_ERR_QUERY = 8'h14;
    localparam logic [WB_AW-1:0] ADR_OUTQ = 8'h18;
    localparam logic [WB_AW-1:0] ADR_ADVISORY = 8'h1c;
    localparam logic [WB_AW-1:0] ADR_CONTROL = 8'h20;

    // operation status register fields
    localparam int ACTIVITY_SUMMARY_BIT_W = 16;
    localparam int ACTIVITY_SUMMARY_BIT_CAPT_BIT = 0;
    localparam int ACTIVITY_SUMMARY_BIT_TRIG_BIT = 5;
    localparam logic [ACTIVITY_SUMMARY_BIT_W-1:0] ACTIVITY_SUMMARY_BIT_MASK_RST = 16'h0021;

    // status byte fields
    localparam int SB_MSG_BIT = 2;
    localparam int SB_MAV_BIT = 4;
    localparam int SB_ACTIVITY_SUMMARY_BIT_BIT = 7;

    // control register write bits
    localparam int CTL_CLEAR_ALL_BIT = 0;
    localparam int CTL_ACQUIRE_BIT = 1;

    // whole state of the top module
    typedef struct packed {
        logic trig_ready;
        logic capt_done;
        logic [ACTIVITY_SUMMARY_BIT_W-1:0] activity_summary_bit_mask;
        logic msg_flag;
        logic [WB_DW-1:0] advisory;
        logic term_seen;
        logic busy;
        logic ack;
        logic [WB_DW-1:0] rdata;
        logic start_acq;
        logic [7:0] status_byte;
    } seq_state_t;

endpackage

//--- rtl/seq_fifo.sv
// first-in first-out store used for the error queue and the output queue
// assumes pushes and pops come from the same clock; flush wins over both
`timescale 1ns/100ps
`default_nettype none
module seq_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int CW = 5
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic push_in,
    input wire logic [W-1:0] push_data_in,
    input wire logic pop_in,
    output logic [W-1:0] rd_data_out,
    output logic [CW-1:0] count_out,
    output logic room_out,
    output logic empty_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
        logic room;
        logic empty;
    } seq_fifo_st_t;

    seq_fifo_st_t s_q;
    seq_fifo_st_t s_d;
    logic [W-1:0] mem [DEPTH];
    logic do_push;
    logic do_pop;

    // pointer step with wrap, depth need not be a power of two
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == LAST_IDX) ? '0 : AW'(p + 1'b1);
    endfunction

    assign do_push = push_in & s_q.room;
    assign do_pop = pop_in & ~s_q.empty;
    assign rd_data_out = mem[s_q.rd];
    assign count_out = s_q.cnt;
    assign room_out = s_q.room;
    assign empty_out = s_q.empty;

    // next pointers and count; flags are registered so users see flops
    always_comb begin
        s_d = s_q;
        if (flush_in) begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
        end else begin
            if (do_push) begin
                s_d.wr = ptr_inc(s_q.wr);
            end
            if (do_pop) begin
                s_d.rd = ptr_inc(s_q.rd);
            end
            if (do_push && !do_pop) begin
                s_d.cnt = CW'(s_q.cnt + 1'b1);
            end else if (do_pop && !do_push) begin
                s_d.cnt = CW'(s_q.cnt - 1'b1);
            end
        end
        s_d.room = (s_d.cnt != FULL_CNT);
        s_d.empty = (s_d.cnt == '0);
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '{wr: '0, rd: '0, cnt: '0, room: 1'b1, empty: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // storage carries data only, no reset needed
    always_ff @(posedge clk_in) begin
        if (do_push && !flush_in) begin
            mem[s_q.wr] <= push_data_in;
        end
    end
endmodule
`default_nettype wire

//--- rtl/seq_top.sv
// status event latches, operation summary, error queue, output queue and advisory holder
// assumes a classic wishbone master, and event inputs that are one-cycle pulses on CLOCK_IN
//
// Overview of operation
// [R1] trigger armed sets operation bit 5 and, through it, status byte bit 7
// [R2] trigger-ready latch sticks until its query read, an operation register read or clear-all
// [R3] acquisition done sets operation bit 0 and, through it, status byte bit 7
// [R4] capture-complete latch sticks until its query read, an operation register read or clear-all
// [R5] host clears the relevant latch after each event to see repeats
// [R6] detected errors are stored and read back first-in first-out
// [R7] on overflow keep oldest, drop newest, last slot becomes code -350
// [R8] error queue holds 30 entries, 29 ordinary plus one overflow
// [R9] each error read returns oldest entry and frees one tail slot
// [R10] error read on an empty queue returns code 0
// [R11] error queue empties at reset, clear-all, and after last read
// [R12] output queue buffers response bytes; nonempty sets status byte bit 4
// [R13] holder keeps last advisory text; host display text leaves message bit alone
// [R14] clear-all clears event latches and queues except the output queue
// [R15] clear-all right after a message terminator also empties output queue
// [R16] after blocking acquire, later queries wait until acquisition completes
// [R17] host stops acquisition and waits for completion before setup changes
// [R18] host polls capture latch with a timeout after a single acquisition
// [R19] status byte bit 7 set while any enabled operation bit is set
// [R20] masked operation bits still latch but add nothing to the summary
// [R21] latch read returns and clears at once; simultaneous event keeps it set
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module seq_top
    import seq_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [WB_AW-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [WB_DW-1:0] WB_DAT_IN,
    output logic [WB_DW-1:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic TRIG_ARMED_IN,
    input wire logic ACQ_DONE_IN,
    input wire logic ERR_VALID_IN,
    input wire logic [ERR_W-1:0] ERR_CODE_IN,
    input wire logic RESP_VALID_IN,
    input wire logic [OUTQ_W-1:0] RESP_BYTE_IN,
    output logic RESP_READY_OUT,
    input wire logic ADVISORY_VALID_IN,
    input wire logic [WB_DW-1:0] ADVISORY_TEXT_IN,
    input wire logic TERMINATOR_IN,
    output logic START_ACQ_OUT,
    output logic [7:0] STATUS_BYTE_OUT
);
    seq_state_t s_q;
    seq_state_t s_d;

    // bus request decode
    logic req;
    logic take;
    logic rd_take;
    logic wr_take;
    logic clear_all;
    logic acquire_cmd;
    logic flush_outq;
    logic [ACTIVITY_SUMMARY_BIT_W-1:0] activity_summary_bit_view;

    // error queue wires
    logic err_push;
    logic [ERR_W-1:0] err_push_data;
    logic err_pop;
    logic [ERR_W-1:0] err_head;
    logic [ERR_CW-1:0] err_count;
    logic err_empty;

    // output queue wires
    logic outq_pop;
    logic [OUTQ_W-1:0] outq_head;
    logic outq_room;
    logic outq_empty;

    // byte-lane merge for writes, used by the mask and advisory registers
    function automatic logic [WB_DW-1:0] lane_merge(input logic [WB_DW-1:0] old_v,
                                                    input logic [WB_DW-1:0] new_v,
                                                    input logic [3:0] sel);
        logic [WB_DW-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    // address match against one register, used for every strobe
    function automatic logic hit(input logic [WB_AW-1:0] adr, input logic [WB_AW-1:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction

    // a read is held off while a blocking acquisition runs; writes always pass
    assign req = WB_CYC_IN & WB_STB_IN & ~s_q.ack;
    assign take = req & ~(s_q.busy & ~WB_WE_IN); // [R16]
    assign rd_take = take & ~WB_WE_IN;
    assign wr_take = take & WB_WE_IN;

    // control strobes from the control register
    assign clear_all = wr_take & hit(WB_ADR_IN, ADR_CONTROL) & WB_SEL_IN[0] & WB_DAT_IN[CTL_CLEAR_ALL_BIT];
    assign acquire_cmd = wr_take & hit(WB_ADR_IN, ADR_CONTROL) & WB_SEL_IN[0] & WB_DAT_IN[CTL_ACQUIRE_BIT];
    assign flush_outq = clear_all & s_q.term_seen; // [R15]

    // the operation register is the two latches placed at their bit positions
    always_comb begin
        activity_summary_bit_view = '0;
        activity_summary_bit_view[ACTIVITY_SUMMARY_BIT_CAPT_BIT] = s_q.capt_done; // [R3]
        activity_summary_bit_view[ACTIVITY_SUMMARY_BIT_TRIG_BIT] = s_q.trig_ready; // [R1]
    end

    // error capture: the entry that would fill the last slot becomes the overflow code,
    // unless a read frees a slot in the same cycle, which leaves the queue short of overflow
    assign err_push = ERR_VALID_IN; // [R6]
    assign err_push_data = ((err_count == ERR_CW'(ERR_DEPTH - 1)) && !err_pop) ? ERR_OVERFLOW_CODE
                                                                              : ERR_CODE_IN; // [R7]
    assign err_pop = rd_take & hit(WB_ADR_IN, ADR_ERR_QUERY); // [R9]
    assign outq_pop = rd_take & hit(WB_ADR_IN, ADR_OUTQ);

    // error queue; full queue refuses the push so newest errors are dropped
    seq_fifo #(
        .W(ERR_W),
        .DEPTH(ERR_DEPTH),
        .CW(ERR_CW)
    ) u_err_queue (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .flush_in(clear_all), // [R11]
        .push_in(err_push), // [R8]
        .push_data_in(err_push_data),
        .pop_in(err_pop),
        .rd_data_out(err_head),
        .count_out(err_count),
        .room_out(),
        .empty_out(err_empty)
    );

    // output queue; its room flag back-pressures the response source
    seq_fifo #(
        .W(OUTQ_W),
        .DEPTH(OUTQ_DEPTH),
        .CW(OUTQ_CW)
    ) u_out_queue (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .flush_in(flush_outq), // [R14]
        .push_in(RESP_VALID_IN),
        .push_data_in(RESP_BYTE_IN),
        .pop_in(outq_pop),
        .rd_data_out(outq_head),
        .count_out(),
        .room_out(outq_room),
        .empty_out(outq_empty)
    );

    // all register and latch behaviour
    always_comb begin
        logic trig_clr;
        logic capt_clr;
        logic [WB_DW-1:0] mask_word;
        logic [7:0] sb;
        trig_clr = 1'b0;
        capt_clr = 1'b0;
        mask_word = '0;
        sb = '0;
        s_d = s_q;

        // ack for one cycle only, so the master sees it fall after it samples it
        s_d.ack = take;
        s_d.start_acq = 1'b0;

        // read data and read side effects
        if (rd_take) begin
            s_d.rdata = '0;
            case (WB_ADR_IN)
                ADR_STATUS_BYTE: begin
                    s_d.rdata[7:0] = s_q.status_byte;
                end
                ADR_ACTIVITY_SUMMARY_BIT_STATUS: begin
                    s_d.rdata[ACTIVITY_SUMMARY_BIT_W-1:0] = activity_summary_bit_view;
                    trig_clr = 1'b1;
                    capt_clr = 1'b1;
                end
                ADR_ACTIVITY_SUMMARY_BIT_MASK: begin
                    s_d.rdata[ACTIVITY_SUMMARY_BIT_W-1:0] = s_q.activity_summary_bit_mask;
                end
                ADR_TRIG_QUERY: begin
                    s_d.rdata[0] = s_q.trig_ready;
                    trig_clr = 1'b1; // [R21]
                end
                ADR_CAPT_QUERY: begin
                    s_d.rdata[0] = s_q.capt_done;
                    capt_clr = 1'b1; // [R21]
                end
                ADR_ERR_QUERY: begin
                    // empty queue answers the no-error code
                    s_d.rdata[ERR_W-1:0] = err_empty ? ERR_NONE_CODE : err_head; // [R10]
                end
                ADR_OUTQ: begin
                    s_d.rdata[OUTQ_W-1:0] = outq_empty ? '0 : outq_head;
                end
                ADR_ADVISORY: begin
                    s_d.rdata = s_q.advisory;
                end
                default: begin
                    s_d.rdata = '0; // unmapped reads answer zero
                end
            endcase
        end

        // writes: mask and display text; control strobes are decoded above
        if (wr_take) begin
            case (WB_ADR_IN)
                ADR_ACTIVITY_SUMMARY_BIT_MASK: begin
                    mask_word = lane_merge({{(WB_DW-ACTIVITY_SUMMARY_BIT_W){1'b0}}, s_q.activity_summary_bit_mask}, WB_DAT_IN, WB_SEL_IN);
                    s_d.activity_summary_bit_mask = mask_word[ACTIVITY_SUMMARY_BIT_W-1:0];
                end
                ADR_ADVISORY: begin
                    // display text from the host leaves the message bit as it is
                    s_d.advisory = lane_merge(s_q.advisory, WB_DAT_IN, WB_SEL_IN); // [R13]
                end
                default: begin
                    s_d.advisory = s_q.advisory;
                end
            endcase
        end

        // clear-all acts on every event latch
        if (clear_all) begin
            trig_clr = 1'b1; // [R14]
            capt_clr = 1'b1;
            s_d.msg_flag = 1'b0;
        end

        // sticky latches; an arriving event beats a clear in the same cycle
        s_d.trig_ready = (s_q.trig_ready & ~trig_clr) | TRIG_ARMED_IN; // [R2]
        s_d.capt_done = (s_q.capt_done & ~capt_clr) | ACQ_DONE_IN; // [R4]

        // device advisory text replaces the old one and flags a message
        if (ADVISORY_VALID_IN) begin
            s_d.advisory = ADVISORY_TEXT_IN; // [R13]
            s_d.msg_flag = 1'b1;
        end

        // terminator tracking: any other bus access between them breaks the pairing
        if (TERMINATOR_IN) begin
            s_d.term_seen = 1'b1;
        end else if (take) begin
            s_d.term_seen = 1'b0;
        end

        // blocking acquire: reads stall until the done event, which covers processing
        if (acquire_cmd) begin
            s_d.busy = 1'b1; // [R16]
            s_d.start_acq = 1'b1;
        end else if (ACQ_DONE_IN) begin
            s_d.busy = 1'b0;
        end

        // status byte, built from next-state latch and message values so it tracks the latches; bit 4 from the queue's current empty flag
        sb[SB_ACTIVITY_SUMMARY_BIT_BIT] = |({s_d.capt_done, s_d.trig_ready} & {s_d.activity_summary_bit_mask[ACTIVITY_SUMMARY_BIT_CAPT_BIT],
                                                              s_d.activity_summary_bit_mask[ACTIVITY_SUMMARY_BIT_TRIG_BIT]}); // [R19] [R20]
        sb[SB_MAV_BIT] = ~outq_empty; // [R12]
        sb[SB_MSG_BIT] = s_d.msg_flag;
        s_d.status_byte = sb;
    end

    // state register
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            s_q <= '{trig_ready: 1'b0, capt_done: 1'b0, activity_summary_bit_mask: ACTIVITY_SUMMARY_BIT_MASK_RST, msg_flag: 1'b0,
                     advisory: '0, term_seen: 1'b0, busy: 1'b0, ack: 1'b0, rdata: '0,
                     start_acq: 1'b0, status_byte: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ports straight from flops
    assign WB_DAT_OUT = s_q.rdata;
    assign WB_ACK_OUT = s_q.ack;
    assign START_ACQ_OUT = s_q.start_acq;
    assign STATUS_BYTE_OUT = s_q.status_byte;
    assign RESP_READY_OUT = outq_room; // registered room flag inside the queue
endmodule
`default_nettype wire

//--- test/seq_monitor.sv
// checker of bus timing, acquire pulse and status byte at the top ports
// assumes a bind onto seq_top and seq_pkg compiled first
`timescale 1ns/100ps
`default_nettype none
module seq_monitor
    import seq_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [WB_AW-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [WB_DW-1:0] WB_DAT_IN,
    input wire logic WB_ACK_OUT,
    input wire logic ACQ_DONE_IN,
    input wire logic RESP_VALID_IN,
    input wire logic RESP_READY_OUT,
    input wire logic START_ACQ_OUT,
    input wire logic [7:0] STATUS_BYTE_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // request the slave may take on this edge
    wire take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    // capture enable as last written, so a masked capture is not expected in the summary
    logic capt_en_q;
    wire capt_en_d = (take && WB_WE_IN && WB_ADR_IN == ADR_ACTIVITY_SUMMARY_BIT_MASK && WB_SEL_IN[0])
        ? WB_DAT_IN[ACTIVITY_SUMMARY_BIT_CAPT_BIT] : capt_en_q;
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            capt_en_q <= ACTIVITY_SUMMARY_BIT_MASK_RST[ACTIVITY_SUMMARY_BIT_CAPT_BIT];
        end else begin
            capt_en_q <= capt_en_d;
        end
    end

    // writes are never stalled, reads may wait on an acquisition
    a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN))
        else $error("ack without a request");
    a_write_latency: assert property (take && WB_WE_IN |=> WB_ACK_OUT)
        else $error("write not answered next cycle");
    a_start_cause: assert property (take && WB_WE_IN && WB_ADR_IN == ADR_CONTROL && WB_SEL_IN[0]
        && WB_DAT_IN[CTL_ACQUIRE_BIT] |-> ##[1:2] START_ACQ_OUT) else $error("acquire write gave no start");
    a_start_pulse: assert property (START_ACQ_OUT |=> !START_ACQ_OUT)
        else $error("start longer than one cycle");
    a_capt_summary: assert property (ACQ_DONE_IN && capt_en_d |=> STATUS_BYTE_OUT[SB_ACTIVITY_SUMMARY_BIT_BIT])
        else $error("capture event missing from summary");
    a_msg_avail: assert property (RESP_VALID_IN && RESP_READY_OUT |-> ##[1:2] STATUS_BYTE_OUT[SB_MAV_BIT])
        else $error("queued byte not flagged");
    a_spare_zero: assert property ((STATUS_BYTE_OUT & 8'h6b) == 8'h00)
        else $error("unused status byte bit set");
    a_reset_values: assert property (disable iff (1'b0) SYS_RST_IN |=> !WB_ACK_OUT && !START_ACQ_OUT
        && RESP_READY_OUT && STATUS_BYTE_OUT == 8'h00) else $error("bad state after reset");
endmodule
`default_nettype wire

//--- test/seq_host.sv
// host model: classic wishbone master issuing commands and queries
// assumes the bench calls bus_cycle and checks its ok flag
`timescale 1ns/100ps
`default_nettype none
module seq_host
    import seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [WB_DW-1:0] dat_in,
    output logic cyc_out,
    output logic stb_out,
    output logic we_out,
    output logic [WB_AW-1:0] adr_out,
    output logic [3:0] sel_out,
    output logic [WB_DW-1:0] dat_out
);
    // idle bus from time zero
    initial begin
        {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
    end

    // one cycle; the host waits for each answer before its next command
    task automatic bus_cycle(input logic w, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d,
                             output logic [WB_DW-1:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clk_in);
        {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} <= {2'b11, w, a, 4'hf, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack_in !== 1'b1 && n < 2000);
        ok = (ack_in === 1'b1);
        q = dat_in;
        // released address and data lines show the inverse, so a stale value cannot pass
        {cyc_out, stb_out, we_out, adr_out, dat_out} <= {3'b000, ~a, ~d};
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench of the status event and error queue block
// assumes seq_pkg, seq_fifo, seq_top, seq_host and seq_monitor compiled before
`timescale 1ns/100ps
`default_nettype none
module tb
    import seq_pkg::*;
;
    typedef struct packed {logic [5:0] e; logic [7:0] a; logic [31:0] x; logic [7:0] s;} seq_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] ev = '0; // trig, acq, err, resp, adv, term
    logic [31:0] dq = '0;
    logic cyc, stb, we, ack, rdy, start, ok;
    logic [7:0] adr, sb;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int miscompares = 0;
    int checks_done = 0;
    int cnt = 0;
    int t0;
    // event pulse, then expected status byte and read
    seq_row_t rows [9] = '{
        '{6'h20, 8'h0c, 32'h1, 8'h80}, '{6'h00, 8'h0c, 32'h0, 8'h00}, '{6'h10, 8'h10, 32'h1, 8'h80},
        '{6'h00, 8'h10, 32'h0, 8'h00}, '{6'h30, 8'h04, 32'h21, 8'h80}, '{6'h00, 8'h04, 32'h0, 8'h00},
        '{6'h00, 8'h08, 32'h21, 8'h00}, '{6'h00, 8'h14, 32'h0, 8'h00}, '{6'h00, 8'h3c, 32'h0, 8'h00}};

    always #2.5 clk = ~clk;
    // cycle count for the stall measurement
    always @(posedge clk) cnt <= cnt + 1;

    seq_top seq_top_inst (.CLOCK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .TRIG_ARMED_IN(ev[5]), .ACQ_DONE_IN(ev[4]), .ERR_VALID_IN(ev[3]), .ERR_CODE_IN(dq[15:0]),
        .RESP_VALID_IN(ev[2]), .RESP_BYTE_IN(dq[7:0]), .RESP_READY_OUT(rdy), .ADVISORY_VALID_IN(ev[1]),
        .ADVISORY_TEXT_IN(dq), .TERMINATOR_IN(ev[0]), .START_ACQ_OUT(start), .STATUS_BYTE_OUT(sb));
    seq_host seq_host_inst (.clk_in(clk), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .stb_out(stb),
        .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));

    task automatic print_verdict;
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_data(input string n, input logic [31:0] x, input logic [31:0] v);
        checks_done++;
        if (v !== x) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, x, v);
        end
    endtask
    // status byte settles within two edges of its cause
    task automatic chk_sb(input logic [7:0] x);
        repeat (2) @(posedge clk);
        #1;
        chk_data("status byte", {24'h0, x}, {24'h0, sb});
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        seq_host_inst.bus_cycle(w, a, d, q, ok);
        if (!ok) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        acc(1'b0, a, 32'h0);
        chk_data($sformatf("read %h", a), x, q);
    endtask
    task automatic pulse(input logic [5:0] m, input logic [31:0] d);
        @(posedge clk);
        ev <= m;
        dq <= d;
        @(posedge clk);
        ev <= '0;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_sb(8'h00);
        chk_data("ready", 32'h1, {31'h0, rdy});
        // host clears each latch by its query, or both by the operation register read, after every event
        foreach (rows[i]) begin
            if (rows[i].e != 6'h00) pulse(rows[i].e, 32'h0);
            chk_sb(rows[i].s);
            rd(rows[i].a, rows[i].x);
        end
        // masked trigger still latches but leaves the summary clear
        acc(1'b1, ADR_ACTIVITY_SUMMARY_BIT_MASK, 32'h1);
        pulse(6'h20, 32'h0);
        chk_sb(8'h00);
        rd(ADR_TRIG_QUERY, 32'h1);
        acc(1'b1, ADR_ACTIVITY_SUMMARY_BIT_MASK, 32'h21);
        // overflow: 29 codes, then the overflow entry, the last push dropped
        for (int i = 1; i <= 31; i++) pulse(6'h08, 32'(i));
        for (int i = 1; i <= 30; i++) rd(ADR_ERR_QUERY, (i < 30) ? 32'(i) : {16'h0, 16'hfea2});
        rd(ADR_ERR_QUERY, 32'h0);
        // clear-all keeps the output queue without a terminator
        pulse(6'h08, 32'h7);
        pulse(6'h20, 32'h0);
        pulse(6'h04, 32'h5a);
        acc(1'b1, ADR_CONTROL, 32'h1);
        rd(ADR_ERR_QUERY, 32'h0);
        rd(ADR_TRIG_QUERY, 32'h0);
        chk_sb(8'h10);
        rd(ADR_OUTQ, 32'h5a);
        pulse(6'h04, 32'h33);
        pulse(6'h01, 32'h0);
        acc(1'b1, ADR_CONTROL, 32'h1);
        chk_sb(8'h00);
        rd(ADR_OUTQ, 32'h0);
        // advisory text sets the message bit, host display text does not
        pulse(6'h02, 32'hcafe0001);
        chk_sb(8'h04);
        rd(ADR_ADVISORY, 32'hcafe0001);
        acc(1'b1, ADR_CONTROL, 32'h1);
        acc(1'b1, ADR_ADVISORY, 32'h12345678);
        chk_sb(8'h00);
        rd(ADR_ADVISORY, 32'h12345678);
        // blocking acquire stalls the query until the done event
        acc(1'b1, ADR_CONTROL, 32'h2);
        t0 = cnt;
        fork
            begin
                repeat (10) @(posedge clk);
                pulse(6'h10, 32'h0);
            end
            rd(ADR_STATUS_BYTE, 32'h80);
        join
        chk_data("stall", 32'h1, {31'h0, (cnt - t0) > 11});
        rd(ADR_CAPT_QUERY, 32'h1);
        // polled wait: clear the latch, then poll with a bounded count; the first read meets the event in the same cycle and returns 0, the next returns 1
        rd(ADR_CAPT_QUERY, 32'h0);
        fork
            pulse(6'h10, 32'h0);
            for (int i = 0; i < 8 && q[0] !== 1'b1; i++) acc(1'b0, ADR_CAPT_QUERY, 32'h0);
        join
        chk_data("polled done", 32'h1, q);
        // setup change only once the acquisition is over, so the reset below has a mask to restore
        acc(1'b1, ADR_ACTIVITY_SUMMARY_BIT_MASK, 32'h1);
        // second reset mid-run drops the latch and restores the mask
        pulse(6'h20, 32'h0);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_sb(8'h00);
        rd(ADR_TRIG_QUERY, 32'h0);
        rd(ADR_ACTIVITY_SUMMARY_BIT_MASK, 32'h21);
        print_verdict();
    end
endmodule

bind seq_top seq_monitor seq_monitor_inst (.CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN),
    .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
    .WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT), .ACQ_DONE_IN(ACQ_DONE_IN), .RESP_VALID_IN(RESP_VALID_IN),
    .RESP_READY_OUT(RESP_READY_OUT), .START_ACQ_OUT(START_ACQ_OUT), .STATUS_BYTE_OUT(STATUS_BYTE_OUT));
`default_nettype wire
